/* File: dv/lxo_chk.sv */
`timescale 1ns/100ps
module lxo_chk import lxo_pkg::*; (
	input wire logic			clk_i,
	input wire logic			resetn_i,
	input wire lxo_pkg::lxo_sfr_req_type	sfr_req_i,
	input wire logic [7:0]			sfr_rdata_o,
	input wire logic [3:0]			factory_trim_i,
	input wire logic			lf_osc_stable_i,
	input wire logic			crystal_stable_i,
	input wire logic			ext_osc_clk_i,
	input wire lxo_pkg::lxo_lf_ctrl_type	lf_ctrl_o,
	input wire lxo_pkg::lxo_ext_ctrl_type	ext_ctrl_o,
	input wire logic			ext_div8_clk_o,
	input wire logic			ext_div8_tick_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	wire logic	rl = sfr_req_i.rd && sfr_req_i.addr == LXO_LF_CTRL_ADDR;
	wire logic	rx = sfr_req_i.rd && sfr_req_i.addr == LXO_EXT_CTRL_ADDR;
	wire logic	wl = sfr_req_i.wr && sfr_req_i.addr == LXO_LF_CTRL_ADDR;
	wire logic	wx = sfr_req_i.wr && sfr_req_i.addr == LXO_EXT_CTRL_ADDR;
	wire logic [7:0]	d = sfr_req_i.wdata;
	wire logic [2:0]	m = ext_ctrl_o.mode;
	// three idle cycles flush the two-flop flag synchroniser
	sequence lf_off; !lf_ctrl_o.lf_en [*3]; endsequence
	chk_lf_write:
		assert property (wl |=> lf_ctrl_o == $past({d[7], d[5:0]})) else $error("lf write lost");
	chk_ext_write:
		assert property (wx |=> {m, ext_ctrl_o.range} == $past({d[6:4], d[2:0]}))
		else $error("ext write lost");
	chk_pin_use:
		assert property ({ext_ctrl_o.pin_a_used, ext_ctrl_o.pin_b_used} == {&m[2:1], |m[2:1]})
		else $error("pin use wrong");
	chk_lf_read:
		assert property (rl |=> {sfr_rdata_o[7], sfr_rdata_o[5:0]} == $past(lf_ctrl_o))
		else $error("lf read wrong");
	chk_ext_read:
		assert property (rx |=> sfr_rdata_o[6:0] == $past({m, 1'b0, ext_ctrl_o.range}))
		else $error("ext read wrong");
	chk_vld_mode:
		assert property (rx && m[2:1] != 2'b11 |=> !sfr_rdata_o[7]) else $error("valid set");
	chk_rdy_off:
		assert property (lf_off ##0 rl |=> !sfr_rdata_o[6]) else $error("ready while off");
	chk_tick_pulse:
		assert property (ext_div8_tick_o |=> !ext_div8_tick_o) else $error("tick too long");
endmodule // lxo_chk
bind lxo_osc_ctrl lxo_chk u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_req_i(sfr_req_i),
	.sfr_rdata_o(sfr_rdata_o), .factory_trim_i(factory_trim_i),
	.lf_osc_stable_i(lf_osc_stable_i), .crystal_stable_i(crystal_stable_i),
	.ext_osc_clk_i(ext_osc_clk_i), .lf_ctrl_o(lf_ctrl_o), .ext_ctrl_o(ext_ctrl_o),
	.ext_div8_clk_o(ext_div8_clk_o), .ext_div8_tick_o(ext_div8_tick_o));

/* File: dv/lxo_osc_ctrl_tb_top.sv */
`timescale 1ns/100ps
module lxo_osc_ctrl_tb_top;
	import lxo_pkg::*;
	logic			clk_i, resetn_i, lf_st, xt_st, xclk, tick, clk8;
	logic [7:0]		rdata;
	lxo_sfr_req_type	req;
	lxo_lf_ctrl_type	lf;
	lxo_ext_ctrl_type	ext;
	int			fails = 0, tests_run = 0, cyc = 0;
	lxo_osc_ctrl u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_req_i(req), .sfr_rdata_o(rdata),
		.factory_trim_i(4'hA), .lf_osc_stable_i(lf_st), .crystal_stable_i(xt_st),
		.ext_osc_clk_i(xclk), .lf_ctrl_o(lf), .ext_ctrl_o(ext), .ext_div8_clk_o(clk8),
		.ext_div8_tick_o(tick));
	lxo_xosc_model u_osc (.mode_i(ext.mode), .clk_o(xclk), .stable_o(xt_st));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			conclude();
		end
	end
	task automatic conclude;
		if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_i) req <= '{1'b0, 1'b1, a, d};
		@(posedge clk_i) req <= '0;
	endtask
	task automatic rd(string nm, logic [7:0] a, logic [7:0] e);
		@(posedge clk_i) req <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge clk_i) req <= '0;
		#1 chk(nm, e, rdata);
	endtask
	task automatic t_lf;
		logic [7:0] v [4] = '{8'h40, 8'h45, 8'h7E, 8'h7F};
		rd("lf reset", LXO_LF_CTRL_ADDR, 8'h28);
		rd("ext reset", LXO_EXT_CTRL_ADDR, 8'h00);
		rd("unmapped", 8'h00, 8'h00);
		foreach (v[i]) begin
			wr(LXO_LF_CTRL_ADDR, v[i]);
			rd("lf fields", LXO_LF_CTRL_ADDR, v[i] & 8'h3F);
		end
		@(posedge clk_i) lf_st <= 1'b1;
		wr(LXO_LF_CTRL_ADDR, 8'h93);
		repeat (2) @(posedge clk_i);
		rd("lf ready", LXO_LF_CTRL_ADDR, 8'hD3);
		chk("lf port", 8'h53, {1'b0, lf});
		wr(LXO_LF_CTRL_ADDR, 8'h13);
		repeat (2) @(posedge clk_i);
		rd("lf stopped", LXO_LF_CTRL_ADDR, 8'h13);
	endtask
	task automatic t_ext;
		logic [7:0] v;
		for (int m = 0; m < 8; m++) begin
			v = {1'b0, m[2:0], 1'b0, m[2:0]};
			wr(LXO_EXT_CTRL_ADDR, v | 8'h88);
			rd("ext fields", LXO_EXT_CTRL_ADDR, v);
			chk("pins", {6'h00, &m[2:1], |m[2:1]}, {6'h00, ext.pin_a_used, ext.pin_b_used});
		end
	endtask
	task automatic t_xtal;
		int k = 0;
		int r = 0;
		logic p = 1'b0;
		wr(LXO_EXT_CTRL_ADDR, 8'h67);
		// start-up wait before polling, shortened to suit the model
		repeat (200) @(posedge clk_i);
		rd("xtal valid", LXO_EXT_CTRL_ADDR, 8'hE7);
		// sample off the edge that launches the outputs
		repeat (1600) begin
			@(posedge clk_i);
			#1;
			k += tick;
			r += (clk8 && !p);
			p = clk8;
		end
		chk("ticks", 8'h01, {7'h00, k >= 24 && k <= 26});
		chk("div8 rises", 8'h01, {7'h00, r >= 24 && r <= 26});
		wr(LXO_EXT_CTRL_ADDR, 8'h27);
		rd("cmos valid", LXO_EXT_CTRL_ADDR, 8'h27);
	endtask
	task automatic t_rc;
		wr(LXO_EXT_CTRL_ADDR, 8'h42);
		rd("rc fields", LXO_EXT_CTRL_ADDR, 8'h42);
		chk("rc pins", 8'h01, {6'h00, ext.pin_a_used, ext.pin_b_used});
		@(posedge clk_i) resetn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		resetn_i <= 1'b1;
		rd("lf re-reset", LXO_LF_CTRL_ADDR, 8'h28);
		rd("ext re-reset", LXO_EXT_CTRL_ADDR, 8'h00);
	endtask
	initial begin
		req = '0;
		lf_st = 1'b0;
		resetn_i = 1'b0;
		repeat (6) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_lf();
		t_ext();
		t_xtal();
		t_rc();
		conclude();
	end
endmodule // lxo_osc_ctrl_tb_top

/* File: dv/lxo_xosc_model.sv */
`timescale 1ns/100ps
module lxo_xosc_model #(parameter int HALF_NS = 20, parameter int SETTLE = 40) (
	input wire logic [2:0]	mode_i,
	output logic		clk_o,
	output logic		stable_o
);
	int n = 0;
	initial begin
		clk_o = 1'b0;
		stable_o = 1'b0;
		forever begin
			#(HALF_NS);
			// circuit off: clock stands still and start-up begins afresh
			if (mode_i[2:1] == 2'b00) n = 0;
			else n = n + 1;
			clk_o = (n > 0) ? ~clk_o : 1'b0;
			stable_o = mode_i[2:1] == 2'b11 && n > SETTLE;
		end
	end
endmodule // lxo_xosc_model

/* File: verilog/lxo_osc_ctrl.sv */
`timescale 1ns/100ps
// Functional notes
// - enable bit 7 of the low-frequency control starts and stops that oscillator
// - bit 6 is a read-only ready flag, 1 once frequency has settled
// - trim in bits 5..2, 0000b fastest, 1111b slowest
// - divider bits 1..0: 00 by 8, 01 by 4, 10 by 2, 11 by 1
// - external mode bits 6..4: 00x off, CMOS, CMOS/2, RC, C, crystal, crystal/2
// - external bit 7 crystal-valid, read-only, only set in crystal modes
// - drive range bits 2..0 steer the external circuit, meaning depends on mode
// - external bit 3 reserved, reads 0, writes ignored
// - capacitor mode: each range code is one K factor, 0.87 up to 1590
// - crystal mode uses both oscillator pins, other active modes only the second
// - external clock divided by eight, resynchronised to system clock, for timers
// - low-frequency oscillator runs at nominal 80 kHz before its divider
module lxo_osc_ctrl
	import lxo_pkg::*;
(
	input  wire logic                      clk_i,
	input  wire logic                      resetn_i,
	input  wire lxo_pkg::lxo_sfr_req_type  sfr_req_i,
	output logic     [7:0]                 sfr_rdata_o,
	input  wire logic [3:0]                factory_trim_i,
	input  wire logic                      lf_osc_stable_i,
	input  wire logic                      crystal_stable_i,
	input  wire logic                      ext_osc_clk_i,
	output lxo_pkg::lxo_lf_ctrl_type       lf_ctrl_o,
	output lxo_pkg::lxo_ext_ctrl_type      ext_ctrl_o,
	output logic                           ext_div8_clk_o,
	output logic                           ext_div8_tick_o
);
	import lxo_pkg::*;

	lxo_state_type st_r;
	lxo_state_type st_nxt;

	logic wr_lf;
	logic wr_xt;
	logic xt_mode;
	logic ext_rise;
	logic [7:0] rd_lf;
	logic [7:0] rd_xt;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt   = st_r;
		wr_lf    = sfr_req_i.wr && (sfr_req_i.addr == LXO_LF_CTRL_ADDR);
		wr_xt    = sfr_req_i.wr && (sfr_req_i.addr == LXO_EXT_CTRL_ADDR);
		xt_mode  = (st_r.mode == LXO_MODE_XTAL) || (st_r.mode == LXO_MODE_XTAL_D2);

		// trim is a strap, caught on the first edge after reset release
		if (!st_r.trim_loaded) begin
			st_nxt.lf_trim     = factory_trim_i;
			st_nxt.trim_loaded = 1'b1;
		end

		if (wr_lf) begin
			st_nxt.lf_en   = sfr_req_i.wdata[LXO_LF_EN_BIT];
			st_nxt.lf_trim = sfr_req_i.wdata[LXO_LF_TRIM_HI:LXO_LF_TRIM_LO];
			st_nxt.lf_div  = sfr_req_i.wdata[LXO_LF_DIV_HI:LXO_LF_DIV_LO];
		end
		if (wr_xt) begin
			// bit 3 and bit 7 are dropped on write
			st_nxt.mode  = lxo_mode_type'(sfr_req_i.wdata[LXO_XT_MODE_HI:LXO_XT_MODE_LO]);
			st_nxt.range = sfr_req_i.wdata[LXO_XT_RANGE_HI:LXO_XT_RANGE_LO];
		end

		// analog flags arrive asynchronously; two flops before any reader
		st_nxt.lf_rdy_sync = {st_r.lf_rdy_sync[0], lf_osc_stable_i && st_r.lf_en};
		st_nxt.xt_vld_sync = {st_r.xt_vld_sync[0], crystal_stable_i && xt_mode};

		// external clock: 3 sync flops (ext_sync), then edge detect against a fourth (ext_prev)
		st_nxt.ext_sync = {st_r.ext_sync[1:0], ext_osc_clk_i};
		ext_rise        = st_r.ext_sync[2] && !st_r.ext_prev;
		st_nxt.div8_tick = 1'b0;
		if (st_r.mode == LXO_MODE_OFF0 || st_r.mode == LXO_MODE_OFF1) begin
			st_nxt.div8_cnt = '0;
			st_nxt.div8_clk = 1'b0;
		end else if (ext_rise) begin
			// jitter is one system clock edge quantisation, i.e. +/-0.5 cycle
			st_nxt.div8_cnt = st_r.div8_cnt + 3'h1;
			if (st_r.div8_cnt == LXO_DIV8_HALF) begin
				st_nxt.div8_clk = 1'b1;
			end else if (st_r.div8_cnt == 3'h7) begin
				st_nxt.div8_clk  = 1'b0;
				st_nxt.div8_tick = 1'b1;
			end
		end
		st_nxt.ext_prev = st_r.ext_sync[2];

		rd_lf = {st_r.lf_en, st_r.lf_rdy_sync[1], st_r.lf_trim, st_r.lf_div};
		rd_xt = {st_r.xt_vld_sync[1] && xt_mode, st_r.mode, 1'b0, st_r.range};
		st_nxt.rdata = 8'h00;
		if (sfr_req_i.rd) begin
			case (sfr_req_i.addr)
				LXO_LF_CTRL_ADDR: begin
					st_nxt.rdata = rd_lf;
				end
				LXO_EXT_CTRL_ADDR: begin
					st_nxt.rdata = rd_xt;
				end
				default: begin
					st_nxt.rdata = 8'h00;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r        <= '0;
			st_r.lf_div <= LXO_LF_DIV_RST;
			st_r.range  <= LXO_XT_RANGE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs to the analog cores and peripherals
	// ----------------------------------------------------------------
	always_comb begin
		sfr_rdata_o          = st_r.rdata;
		lf_ctrl_o.lf_en      = st_r.lf_en;
		lf_ctrl_o.lf_trim    = st_r.lf_trim;
		lf_ctrl_o.lf_div     = st_r.lf_div;
		ext_ctrl_o.mode      = st_r.mode;
		ext_ctrl_o.range     = st_r.range;
		ext_ctrl_o.pin_a_used = st_r.mode[2] && st_r.mode[1];
		ext_ctrl_o.pin_b_used = st_r.mode[2] || st_r.mode[1];
		ext_div8_clk_o       = st_r.div8_clk;
		ext_div8_tick_o      = st_r.div8_tick;
	end

endmodule // lxo_osc_ctrl

/* File: verilog/lxo_pkg.sv */
package lxo_pkg;

	// ----------------------------------------------------------------
	// register addresses (special function register space)
	// ----------------------------------------------------------------
	localparam logic [7:0] LXO_LF_CTRL_ADDR  = 8'h86;
	localparam logic [7:0] LXO_EXT_CTRL_ADDR = 8'hB1;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int LXO_LF_EN_BIT    = 7;
	localparam int LXO_LF_RDY_BIT   = 6;
	localparam int LXO_LF_TRIM_HI   = 5;
	localparam int LXO_LF_TRIM_LO   = 2;
	localparam int LXO_LF_DIV_HI    = 1;
	localparam int LXO_LF_DIV_LO    = 0;
	localparam int LXO_XT_VLD_BIT   = 7;
	localparam int LXO_XT_MODE_HI   = 6;
	localparam int LXO_XT_MODE_LO   = 4;
	localparam int LXO_XT_RANGE_HI  = 2;
	localparam int LXO_XT_RANGE_LO  = 0;

	// ----------------------------------------------------------------
	// reset values and divider half-count compare value
	// ----------------------------------------------------------------
	localparam logic [1:0] LXO_LF_DIV_RST   = 2'h0;
	localparam logic [2:0] LXO_XT_RANGE_RST = 3'h0;
	localparam logic [2:0] LXO_DIV8_HALF    = 3'h3;

	// ----------------------------------------------------------------
	// external oscillator modes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		LXO_MODE_OFF0    = 3'b000,
		LXO_MODE_OFF1    = 3'b001,
		LXO_MODE_CMOS    = 3'b010,
		LXO_MODE_CMOS_D2 = 3'b011,
		LXO_MODE_RC      = 3'b100,
		LXO_MODE_CAP     = 3'b101,
		LXO_MODE_XTAL    = 3'b110,
		LXO_MODE_XTAL_D2 = 3'b111
	} lxo_mode_type;

	// ----------------------------------------------------------------
	// nominal oscillator rate, for documentation of the analog side
	// ----------------------------------------------------------------
	localparam int LXO_LF_NOMINAL_KHZ = 80;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} lxo_sfr_req_type;

	typedef struct packed {
		logic       lf_en;
		logic [3:0] lf_trim;
		logic [1:0] lf_div;
	} lxo_lf_ctrl_type;

	typedef struct packed {
		logic         pin_a_used;
		logic         pin_b_used;
		lxo_mode_type mode;
		logic [2:0]   range;
	} lxo_ext_ctrl_type;

	typedef struct packed {
		logic             lf_en;
		logic [3:0]       lf_trim;
		logic [1:0]       lf_div;
		logic             trim_loaded;
		lxo_mode_type     mode;
		logic [2:0]       range;
		logic [1:0]       lf_rdy_sync;
		logic [1:0]       xt_vld_sync;
		logic [2:0]       ext_sync;
		logic             ext_prev;
		logic [2:0]       div8_cnt;
		logic             div8_clk;
		logic             div8_tick;
		logic [7:0]       rdata;
	} lxo_state_type;

endpackage
